// [inc/pfs_pkg.sv]
// shared constants and types of the program flow sequencer
package pfs_pkg;
  // widths
  localparam int PC_W = 13;
  localparam int PM_W = 16;
  localparam int AXI_AW = 12;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  // fixed vectors
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC = 13'h0004;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_PCL = 10'h002;
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_LATCH = 10'h00a;
  localparam logic [9:0] IDX_IRQF = 10'h00c;
  localparam logic [9:0] IDX_TAH = 10'h110;
  localparam logic [9:0] IDX_TAL = 10'h111;
  localparam logic [9:0] IDX_TDH = 10'h112;
  // status field positions
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  // reset values
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PD = 1'b1;
  localparam logic [4:0] RST_LATCH = 5'h00;
  localparam logic [4:0] RST_TAH = 5'h00;
  localparam logic [7:0] RST_TAL = 8'h00;
  localparam logic [7:0] RST_TDH = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // lookup sequence
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_ADDR = 3'b010,
    LK_DATA = 3'b100
  } pfs_lookup_type;
endpackage

// [inc/pfs_stack_if.sv]
// link between the sequencer and its return address stack
`timescale 1ns/1ps
interface pfs_stack_if;
  logic push;
  logic pop;
  logic clear;
  logic [12:0] push_data;
  logic [12:0] top;
  modport core (output push, output pop, output clear,
    output push_data, input top);
  modport store (input push, input pop, input clear,
    input push_data, output top);
endinterface

// [rtl/pfs_stack.sv]
// eight level return address stack
`timescale 1ns/1ps
module pfs_stack (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // sequencer side
  pfs_stack_if.store st_if
);
  typedef struct packed {
    logic [pfs_pkg::STACK_DEPTH-1:0][pfs_pkg::PC_W-1:0] mem;
    logic [pfs_pkg::STACK_PTR_W-1:0] ptr;
  } pfs_stack_state_type;

  pfs_stack_state_type s_reg;
  pfs_stack_state_type s_next;

  // circular: a ninth push overwrites the oldest entry, as there is no trap
  always_comb begin
    s_next = s_reg;
    if (st_if.clear) begin
      s_next.ptr = '0;
    end else if (st_if.push) begin
      s_next.mem[s_reg.ptr] = st_if.push_data;
      s_next.ptr = s_reg.ptr + 3'h1;
    end else if (st_if.pop) begin
      s_next.ptr = s_reg.ptr - 3'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // top of stack is the last pushed entry
  assign st_if.top = s_reg.mem[s_reg.ptr - 3'h1];
endmodule

// [rtl/pfs_top.sv]
// program flow sequencer: pc, vectors, reset cause, lookup, register port
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pfs_top (
  // clock and power-on reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // other reset sources, asynchronous pins
  input wire logic watchdog_reset_i,
  input wire logic low_supply_reset_i,
  // instruction decoder strobes
  input wire logic pc_step_i,
  input wire logic jump_i,
  input wire logic [12:0] jump_addr_i,
  input wire logic add_pcl_i,
  input wire logic [7:0] working_register_i,
  input wire logic irq_accept_i,
  input wire logic return_from_irq_i,
  input wire logic lookup_to_register_i,
  input wire logic lookup_to_accumulator_i,
  input wire logic sleep_i,
  input wire logic clear_watchdog_i,
  input wire logic [7:0] irq_request_flags_i,
  // decoder results
  output logic [12:0] pc_o,
  output logic reset_active_o,
  output logic lookup_busy_o,
  output logic lookup_done_o,
  output logic lookup_to_acc_o,
  output logic [7:0] lookup_data_o,
  // program memory
  output logic [12:0] pm_addr_o,
  input wire logic [15:0] pm_data_i,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [2:0] wdt_sync;
    logic [2:0] lvs_sync;
    logic rst_act;
    logic [12:0] pc;
    logic [4:0] latch;
    logic [4:0] tah;
    logic [7:0] tal;
    logic [7:0] tdh;
    logic to_flag;
    logic pd_flag;
    pfs_pkg::pfs_lookup_type lk;
    logic lk_acc;
    logic [7:0] lk_low;
    logic lk_done;
    logic [12:0] pm_addr;
    logic aw_held;
    logic [9:0] aw_idx;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pfs_state_type;

  pfs_state_type s_reg;
  pfs_state_type s_next;
  pfs_stack_if stk_if ();

  logic wdt_lvl;
  logic lvs_lvl;
  logic hold;
  logic do_write;

  // known register index, shared by the read and write paths
  function automatic logic mapped(input logic [9:0] idx);
    return idx == pfs_pkg::IDX_PCL || idx == pfs_pkg::IDX_STATUS ||
      idx == pfs_pkg::IDX_LATCH || idx == pfs_pkg::IDX_IRQF ||
      idx == pfs_pkg::IDX_TAH || idx == pfs_pkg::IDX_TAL ||
      idx == pfs_pkg::IDX_TDH;
  endfunction

  // byte address to register index
  function automatic logic [9:0] to_idx(input logic [11:0] addr);
    return addr[11:2];
  endfunction

  // reset level counts once stages two and three agree
  assign wdt_lvl = s_reg.wdt_sync[1] & s_reg.wdt_sync[2];
  assign lvs_lvl = s_reg.lvs_sync[1] & s_reg.lvs_sync[2];
  assign hold = wdt_lvl | lvs_lvl;
  assign do_write = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;

  always_comb begin
    s_next = s_reg;
    s_next.wdt_sync = {s_reg.wdt_sync[1:0], watchdog_reset_i};
    s_next.lvs_sync = {s_reg.lvs_sync[1:0], low_supply_reset_i};
    s_next.rst_act = hold;
    s_next.lk_done = 1'b0;
    stk_if.push = 1'b0;
    stk_if.pop = 1'b0;
    stk_if.clear = 1'b0;
    stk_if.push_data = s_reg.pc;

    // program counter: reset, then interrupt, return, writes, jumps
    if (hold) begin
      // the bus handshake survives so no transfer is torn in half
      s_next.pc = pfs_pkg::RESET_VEC;
      s_next.latch = pfs_pkg::RST_LATCH;
      s_next.tah = pfs_pkg::RST_TAH;
      s_next.tal = pfs_pkg::RST_TAL;
      s_next.tdh = pfs_pkg::RST_TDH;
      s_next.lk = pfs_pkg::LK_IDLE;
      s_next.lk_acc = 1'b0;
      s_next.lk_low = '0;
      stk_if.clear = 1'b1;
      // low supply acts like power-on; watchdog drops the timeout flag
      s_next.to_flag = lvs_lvl ? pfs_pkg::RST_TO : 1'b0;
      s_next.pd_flag = pfs_pkg::RST_PD;
    end else begin
      if (irq_accept_i) begin
        stk_if.push = 1'b1;
        s_next.pc = pfs_pkg::IRQ_VEC;
      end else if (return_from_irq_i) begin
        stk_if.pop = 1'b1;
        s_next.pc = stk_if.top;
      end else if (do_write && s_reg.w_lane0 &&
          s_reg.aw_idx == pfs_pkg::IDX_PCL) begin
        s_next.pc = {s_reg.latch, s_reg.w_byte};
      end else if (add_pcl_i) begin
        // 8-bit sum drops its carry so the jump stays in the page
        s_next.pc = {s_reg.latch,
          8'(s_reg.pc[7:0] + working_register_i)};
      end else if (jump_i) begin
        s_next.pc = jump_addr_i;
      end else if (pc_step_i) begin
        s_next.pc = s_reg.pc + 13'h0001;
      end

      // sleep clears, clear-watchdog sets; the set wins a tie
      if (clear_watchdog_i) begin
        s_next.to_flag = 1'b1;
        s_next.pd_flag = 1'b1;
      end else if (sleep_i) begin
        s_next.to_flag = 1'b1;
        s_next.pd_flag = 1'b0;
      end

      // table lookup: present pointer address, then take the word
      unique case (s_reg.lk)
        pfs_pkg::LK_IDLE: begin
          if (lookup_to_register_i || lookup_to_accumulator_i) begin
            s_next.lk = pfs_pkg::LK_ADDR;
            s_next.lk_acc = lookup_to_accumulator_i;
          end
        end
        pfs_pkg::LK_ADDR: begin
          s_next.lk = pfs_pkg::LK_DATA;
        end
        pfs_pkg::LK_DATA: begin
          s_next.lk_low = pm_data_i[7:0];
          s_next.tdh = pm_data_i[15:8];
          s_next.lk_done = 1'b1;
          s_next.lk = pfs_pkg::LK_IDLE;
        end
        default: begin
          s_next.lk = pfs_pkg::LK_IDLE;
        end
      endcase

      // software register writes; read-only and flag bits are ignored
      if (do_write && s_reg.w_lane0) begin
        if (s_reg.aw_idx == pfs_pkg::IDX_LATCH) begin
          s_next.latch = s_reg.w_byte[4:0];
        end
        if (s_reg.aw_idx == pfs_pkg::IDX_TAH) begin
          s_next.tah = s_reg.w_byte[4:0];
        end
        if (s_reg.aw_idx == pfs_pkg::IDX_TAL) begin
          s_next.tal = s_reg.w_byte;
        end
      end
    end

    // memory address: table pointers while a lookup reads, else pc
    if (s_next.lk == pfs_pkg::LK_ADDR) begin
      s_next.pm_addr = {s_next.tah, s_next.tal};
    end else begin
      s_next.pm_addr = s_next.pc;
    end

    // write channel: address and data held apart, answered together
    if (s_axi_awvalid && !s_reg.aw_held && !s_reg.bvalid) begin
      s_next.aw_held = 1'b1;
      s_next.aw_idx = to_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && !s_reg.w_held && !s_reg.bvalid) begin
      s_next.w_held = 1'b1;
      s_next.w_byte = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.aw_idx) ? pfs_pkg::RESP_OKAY :
        pfs_pkg::RESP_SLVERR;
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // read channel answers one cycle after the address is taken
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = mapped(to_idx(s_axi_araddr)) ?
        pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
      s_next.rdata = '0;
      unique case (to_idx(s_axi_araddr))
        pfs_pkg::IDX_PCL: s_next.rdata[7:0] = s_reg.pc[7:0];
        pfs_pkg::IDX_STATUS: begin
          s_next.rdata[pfs_pkg::STAT_TO_BIT] = s_reg.to_flag;
          s_next.rdata[pfs_pkg::STAT_PD_BIT] = s_reg.pd_flag;
        end
        pfs_pkg::IDX_LATCH: s_next.rdata[4:0] = s_reg.latch;
        pfs_pkg::IDX_IRQF: s_next.rdata[7:0] = irq_request_flags_i;
        pfs_pkg::IDX_TAH: s_next.rdata[4:0] = s_reg.tah;
        pfs_pkg::IDX_TAL: s_next.rdata[7:0] = s_reg.tal;
        pfs_pkg::IDX_TDH: s_next.rdata[7:0] = s_reg.tdh;
        default: s_next.rdata = '0;
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // power-on reset: vector zero and default register values
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.pc <= pfs_pkg::RESET_VEC;
      s_reg.pm_addr <= pfs_pkg::RESET_VEC;
      s_reg.to_flag <= pfs_pkg::RST_TO;
      s_reg.pd_flag <= pfs_pkg::RST_PD;
      s_reg.latch <= pfs_pkg::RST_LATCH;
      s_reg.tah <= pfs_pkg::RST_TAH;
      s_reg.tal <= pfs_pkg::RST_TAL;
      s_reg.tdh <= pfs_pkg::RST_TDH;
      s_reg.lk <= pfs_pkg::LK_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  pfs_stack u_stack (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .st_if(stk_if)
  );

  // outputs straight from the state
  assign pc_o = s_reg.pc;
  assign reset_active_o = s_reg.rst_act;
  assign lookup_busy_o = s_reg.lk != pfs_pkg::LK_IDLE;
  assign lookup_done_o = s_reg.lk_done;
  assign lookup_to_acc_o = s_reg.lk_acc;
  assign lookup_data_o = s_reg.lk_low;
  assign pm_addr_o = s_reg.pm_addr;
  assign s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
  assign s_axi_wready = ~s_reg.w_held & ~s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
endmodule

// [dv/pfs_asserts.sv]
// assertion checker bound to the sequencer top ports
`timescale 1ns/1ps
module pfs_asserts (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // secondary resets and strobes
  input wire logic watchdog_reset_i,
  input wire logic low_supply_reset_i,
  input wire logic add_pcl_i,
  input wire logic [7:0] working_register_i,
  input wire logic irq_accept_i,
  input wire logic return_from_irq_i,
  input wire logic lookup_to_register_i,
  input wire logic lookup_to_accumulator_i,
  input wire logic [15:0] pm_data_i,
  // results
  input wire logic [12:0] pc_o,
  input wire logic reset_active_o,
  input wire logic lookup_busy_o,
  input wire logic lookup_done_o,
  input wire logic [7:0] lookup_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // conservative: a reset pin or its hold masks every strobe
  wire quiet = !reset_active_o && !watchdog_reset_i && !low_supply_reset_i;
  // lookup steps: start, two busy cycles, one done cycle
  sequence s_lk_go;
    quiet && !lookup_busy_o &&
      (lookup_to_register_i || lookup_to_accumulator_i);
  endsequence
  sequence s_lk_run;
    lookup_busy_o[*2] ##1 (lookup_done_o && !lookup_busy_o);
  endsequence
  // interrupt entry directly followed by its return
  sequence s_irq_ret;
    quiet && irq_accept_i ##1 quiet && return_from_irq_i && !irq_accept_i;
  endsequence
  chk_hold_pc: assert property (
    reset_active_o && $past(reset_active_o) |-> pc_o == pfs_pkg::RESET_VEC)
    else $error("pc left zero during reset hold");
  chk_reset_src: assert property (
    (watchdog_reset_i || low_supply_reset_i)[*6] |-> reset_active_o)
    else $error("reset pin did not start a hold");
  chk_irq_vector: assert property (
    quiet && irq_accept_i |=> pc_o == pfs_pkg::IRQ_VEC)
    else $error("pc not at interrupt vector");
  chk_irq_return: assert property (
    s_irq_ret |=> pc_o == $past(pc_o, 2))
    else $error("return did not restore pc");
  chk_lookup_flow: assert property (
    s_lk_go |=> s_lk_run) else $error("lookup steps out of order");
  chk_lookup_data: assert property (
    lookup_done_o |-> lookup_data_o == 8'($past(pm_data_i)))
    else $error("lookup data not the low byte");
  chk_done_once: assert property (
    lookup_done_o |=> !lookup_done_o) else $error("done longer than one");
  chk_add_wrap: assert property (
    quiet && add_pcl_i && !irq_accept_i && !return_from_irq_i |=>
      pc_o[7:0] == $past(pc_o[7:0]) + $past(working_register_i))
    else $error("pc low sum wrong");
endmodule

// [dv/pfs_rom_model.sv]
// program memory model: synchronous rom, one cycle read
`timescale 1ns/1ps
module pfs_rom_model (
  // clock
  input wire logic clock_i,
  // address in, word out
  input wire logic [12:0] addr_i,
  output logic [15:0] data_o
);
  // scrambled content: high byte from address bits 7:0, low byte from bits 12:5
  function automatic logic [15:0] word(input logic [12:0] a);
    return {a[7:0] ^ 8'h5a, a[12:5] ^ 8'hc3};
  endfunction
  // one cycle latency, no earlier answer than the real store
  always_ff @(posedge clock_i) begin
    data_o <= word(addr_i);
  end
endmodule

// [dv/pfs_top_test.sv]
// self-checking bench of the program flow sequencer
`timescale 1ns/1ps
module pfs_top_test;
  // strobe bit positions in stb
  localparam int STEP = 0, JMP = 1, ADD = 2, IRQ = 3, RET = 4;
  localparam int LKR = 5, LKA = 6, SLP = 7, CWD = 8;
  // stimulus with time zero values
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic watchdog_reset_i = 1'b0;
  logic low_supply_reset_i = 1'b0;
  logic [8:0] stb = 9'h000;
  logic pc_step_i, jump_i, add_pcl_i, irq_accept_i, return_from_irq_i;
  logic lookup_to_register_i, lookup_to_accumulator_i, sleep_i;
  logic clear_watchdog_i;
  logic [12:0] jump_addr_i = 13'h00fc;
  logic [7:0] working_register_i = 8'h05;
  logic [7:0] irq_request_flags_i = 8'h81;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  // observed outputs
  logic [12:0] pc_o, pm_addr_o;
  logic reset_active_o, lookup_busy_o, lookup_done_o, lookup_to_acc_o;
  logic [7:0] lookup_data_o;
  logic [15:0] pm_data_i;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int fails = 0;
  int n_compared = 0;
  // one vector for all strobes, so a pulse is a single assignment
  assign {clear_watchdog_i, sleep_i, lookup_to_accumulator_i,
    lookup_to_register_i, return_from_irq_i, irq_accept_i, add_pcl_i,
    jump_i, pc_step_i} = stb;
  pfs_top dut (.*);
  pfs_rom_model rom (
    .clock_i(clock_i),
    .addr_i(pm_addr_o),
    .data_o(pm_data_i)
  );
  // 250 mhz clock
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a wait that used up its bound ends the run as a mismatch
  task automatic limit(input int n);
    if (n >= 40) begin
      fails++;
      test_done;
    end
  endtask
  function automatic logic [31:0] stat(input logic to, input logic pd);
    return (32'(to) << pfs_pkg::STAT_TO_BIT) |
      (32'(pd) << pfs_pkg::STAT_PD_BIT);
  endfunction
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    int n;
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge clock_i);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; (pa || pw) && n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    limit(n);
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_bvalid) break;
    end
    limit(n);
  endtask
  task automatic rd(input logic [9:0] i, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge clock_i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_arready) break;
    end
    limit(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_rvalid) break;
    end
    limit(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input string s, input logic [9:0] i,
    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(s, e, d);
  endtask
  // one cycle strobe, returns where the result has settled
  task automatic pulse(input int k);
    @(posedge clock_i);
    stb <= 9'(1 << k);
    @(posedge clock_i);
    stb <= 9'h000;
    @(negedge clock_i);
  endtask
  task automatic t_por;
    logic [31:0] d;
    logic [1:0] r;
    chk("pc", 13'h0000, pc_o);
    chk("fetch", 13'h0000, pm_addr_o);
    rchk("status", pfs_pkg::IDX_STATUS, stat(1'b1, 1'b1));
    rchk("tah", pfs_pkg::IDX_TAH, 32'h0);
    rchk("latch", pfs_pkg::IDX_LATCH, 32'h0);
    rd(10'h3ff, d, r);
    chk("unmapped", 32'(pfs_pkg::RESP_SLVERR), 32'(r));
    // bresp stands after the handshake until the next write is executed
    wr(10'h3ff, 32'h0);
    chk("bresp", 32'(pfs_pkg::RESP_SLVERR), 32'(s_axi_bresp));
    // a write without lane zero must leave the pointer alone
    s_axi_wstrb <= 4'he;
    wr(pfs_pkg::IDX_TAL, 32'h77);
    s_axi_wstrb <= 4'hf;
    chk("bresp", 32'(pfs_pkg::RESP_OKAY), 32'(s_axi_bresp));
    rchk("tal", pfs_pkg::IDX_TAL, 32'h0);
  endtask
  task automatic look(input int k, input logic [12:0] a);
    int n;
    pulse(k);
    for (n = 0; n < 40 && lookup_done_o !== 1'b1; n++)
      @(negedge clock_i);
    limit(n);
    chk("lookup data", 32'(rom.word(a) & 16'h00ff),
      32'(lookup_data_o));
    chk("lookup dest", 32'(k == LKA), 32'(lookup_to_acc_o));
    rchk("tdh", pfs_pkg::IDX_TDH, 32'(rom.word(a) >> 8));
  endtask
  task automatic t_lookup;
    wr(pfs_pkg::IDX_TAH, 32'h06);
    wr(pfs_pkg::IDX_TAL, 32'h02);
    look(LKR, 13'h0602);
    wr(pfs_pkg::IDX_TDH, 32'h00);
    rchk("tdh", pfs_pkg::IDX_TDH, 32'(rom.word(13'h0602) >> 8));
    wr(pfs_pkg::IDX_TAH, 32'hff);
    rchk("tah", pfs_pkg::IDX_TAH, 32'h1f);
    wr(pfs_pkg::IDX_TAL, 32'hff);
    rchk("tal", pfs_pkg::IDX_TAL, 32'hff);
    look(LKA, 13'h1fff);
  endtask
  // computed jump across a page edge must wrap inside the page
  task automatic t_jump;
    wr(pfs_pkg::IDX_LATCH, 32'h01);
    pulse(JMP);
    pulse(ADD);
    chk("pc", {5'h01, 8'hfc + 8'h05}, pc_o);
    wr(pfs_pkg::IDX_LATCH, 32'h02);
    wr(pfs_pkg::IDX_PCL, 32'h33);
    chk("pc", 13'h0233, pc_o);
    chk("fetch", 13'h0233, pm_addr_o);
  endtask
  // interrupt entry with the return on the very next cycle
  task automatic t_irq;
    jump_addr_i <= 13'h0123;
    pulse(JMP);
    pulse(STEP);
    rchk("irq flags", pfs_pkg::IDX_IRQF, 32'h81);
    @(posedge clock_i);
    stb <= 9'(1 << IRQ);
    @(posedge clock_i);
    stb <= 9'(1 << RET);
    @(negedge clock_i);
    chk("pc", pfs_pkg::IRQ_VEC, pc_o);
    @(posedge clock_i);
    stb <= 9'h000;
    @(negedge clock_i);
    chk("pc", 13'h0124, pc_o);
    // only the pc is saved: status is the handler's job and stays as it was
    rchk("status", pfs_pkg::IDX_STATUS, stat(1'b1, 1'b1));
  endtask
  task automatic t_reset(input logic w, input logic l,
    input logic [31:0] st);
    int n;
    wr(pfs_pkg::IDX_TAL, 32'h5a);
    watchdog_reset_i <= w;
    low_supply_reset_i <= l;
    for (n = 0; n < 40 && reset_active_o !== 1'b1; n++)
      @(negedge clock_i);
    limit(n);
    pulse(IRQ);
    chk("pc", 13'h0000, pc_o);
    chk("fetch", 13'h0000, pm_addr_o);
    rchk("tal", pfs_pkg::IDX_TAL, 32'h0);
    watchdog_reset_i <= 1'b0;
    low_supply_reset_i <= 1'b0;
    for (n = 0; n < 40 && reset_active_o !== 1'b0; n++)
      @(negedge clock_i);
    limit(n);
    rchk("status", pfs_pkg::IDX_STATUS, st);
  endtask
  // sleep and clear-watchdog in one cycle: the setting clear wins
  task automatic t_tie;
    pulse(SLP);
    @(posedge clock_i);
    stb <= 9'((1 << SLP) | (1 << CWD));
    @(posedge clock_i);
    stb <= 9'h000;
    rchk("status", pfs_pkg::IDX_STATUS, stat(1'b1, 1'b1));
  endtask
  // main sequence after a three cycle reset
  initial begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_por;
    t_lookup;
    t_jump;
    t_irq;
    t_reset(1'b1, 1'b0, stat(1'b0, 1'b1));
    t_reset(1'b0, 1'b1, stat(1'b1, 1'b1));
    pulse(SLP);
    rchk("status", pfs_pkg::IDX_STATUS, stat(1'b1, 1'b0));
    pulse(CWD);
    rchk("status", pfs_pkg::IDX_STATUS, stat(1'b1, 1'b1));
    t_tie;
    test_done;
  end
endmodule
bind pfs_top pfs_asserts chk (.*);
